// file: ccoi_regs.vh
`ifndef CCOI_REGS_VH
`define CCOI_REGS_VH
// register indices (printed offsets); byte address is index * 4
`define CCOI_IDX_GRP_FIFO_IE     12'h40c
`define CCOI_IDX_GEN_STATUS      12'h40e
`define CCOI_IDX_XFER_CMD        12'h40f
`define CCOI_IDX_LINK_OVF_BASE   12'h410
`define CCOI_IDX_GRP_OVF_BASE    12'h420
`define CCOI_IDX_CNT_UPPER       12'h430
`define CCOI_IDX_CNT_MID         12'h431
`define CCOI_IDX_CNT_SELECT      12'h432
`define CCOI_IDX_GRP_OVF_IE      12'h433
`define CCOI_IDX_GEN_STATUS_IE   12'h434
`define CCOI_IDX_LINK_OVF_IE     12'h435
// reset values
`define CCOI_RST_XFER_CMD        16'h0080
`define CCOI_RST_ZERO            16'h0000
// transfer command fields
`define CCOI_CMD_SNAP_TRIG       10
`define CCOI_CMD_MODE_HI         9
`define CCOI_CMD_MODE_LO         8
`define CCOI_CMD_DONE            7
`define CCOI_CMD_TOGGLE          6
`define CCOI_CMD_IE_VAL          3
`define CCOI_CMD_DIR             2
`define CCOI_CMD_OP_HI           1
`define CCOI_CMD_OP_LO           0
// latch modes
`define CCOI_MODE_OFF            2'h0
`define CCOI_MODE_EVERY          2'h1
`define CCOI_MODE_DIVIDED        2'h2
`define CCOI_MODE_SOFT           2'h3
// operations
`define CCOI_OP_CLEAR_ALL        2'h0
`define CCOI_OP_VALUE            2'h1
`define CCOI_OP_IE               2'h2
// snapshot divider (edges of snapshot clock)
`define CCOI_SNAP_DIV            8000
// transfer completion latency in ref_clk cycles
`define CCOI_XFER_CYCLES         4'h4
`endif

// file: ccoi_top.v
// The APB interface to the registers is this design's own decision.
`timescale 1ns/1ps
`include "ccoi_regs.vh"
module ccoi_top #(
	parameter NLINK = 16,
	parameter NGRP  = 8
) (
	input  wire          ref_clk,
	input  wire          nrst,
	input  wire          psel,
	input  wire          penable,
	input  wire          pwrite,
	input  wire [15:0]   paddr,
	input  wire [31:0]   pwdata,
	output wire [31:0]   prdata,
	output wire          pready,
	output wire          pslverr,
	input  wire          any_write_access,
	input  wire          counter_snapshot_clock,
	input  wire          utopia_out_clk_lost,
	input  wire          utopia_in_clk_lost,
	input  wire          tx_fifo_overflow,
	input  wire          tx_cell_ram_full,
	input  wire [NLINK*13-1:0] link_ovf_event,
	input  wire [NGRP*5-1:0]   grp_ovf_event,
	output reg           snapshot_pulse,
	output reg           xfer_start,
	output reg  [1:0]    xfer_op,
	output reg           xfer_dir,
	output reg           xfer_ie_val,
	output reg  [3:0]    xfer_cnt_type,
	output reg  [4:0]    xfer_cnt_index,
	output reg  [23:0]   xfer_wdata,
	input  wire          xfer_rvalid,
	input  wire [23:0]   xfer_rdata,
	output wire          irq
);
	wire          acc   = psel & penable;
	wire          wr    = acc & pwrite;
	wire [11:0]   idx   = paddr[13:2];
	wire          aligned = (paddr[1:0] == 2'h0) && (paddr[15:14] == 2'h0);
	wire [15:0]   wd    = pwdata[15:0];

	reg  [7:0]    grp_fifo_ie_reg;
	reg  [3:0]    gen_status_reg;
	reg  [15:0]   cmd_reg;
	reg  [7:0]    cnt_upper_reg;
	reg  [15:0]   cnt_mid_reg;
	reg  [8:0]    cnt_select_reg;
	reg  [7:0]    grp_ovf_ie_reg;
	reg  [3:0]    gen_status_ie_reg;
	reg  [NLINK-1:0] link_ovf_ie_reg;
	reg  [12:0]   link_ovf_reg [0:NLINK-1];
	reg  [4:0]    grp_ovf_reg [0:NGRP-1];
	reg  [3:0]    xfer_cnt_reg;
	reg           xfer_busy_reg;
	reg  [2:0]    snap_sync_reg;
	reg  [12:0]   snap_div_reg;
	reg           snap_hold_reg;
	reg  [3:0]    ev_sync1_reg;
	reg  [3:0]    ev_sync2_reg;
	reg  [3:0]    ev_sync3_reg;

	wire sel_ie      = aligned && (idx == `CCOI_IDX_GRP_FIFO_IE);
	wire sel_gs      = aligned && (idx == `CCOI_IDX_GEN_STATUS);
	wire sel_cmd     = aligned && (idx == `CCOI_IDX_XFER_CMD);
	wire sel_up      = aligned && (idx == `CCOI_IDX_CNT_UPPER);
	wire sel_mid     = aligned && (idx == `CCOI_IDX_CNT_MID);
	wire sel_sel     = aligned && (idx == `CCOI_IDX_CNT_SELECT);
	wire sel_gie     = aligned && (idx == `CCOI_IDX_GRP_OVF_IE);
	wire sel_gsie    = aligned && (idx == `CCOI_IDX_GEN_STATUS_IE);
	wire sel_lie     = aligned && (idx == `CCOI_IDX_LINK_OVF_IE);
	// bases held at index width so the slice compares stay exact
	localparam [11:0] LINK_BASE = `CCOI_IDX_LINK_OVF_BASE;
	localparam [11:0] GRP_BASE  = `CCOI_IDX_GRP_OVF_BASE;
	wire sel_link    = aligned && (idx[11:4] == LINK_BASE[11:4]);
	wire sel_grp     = aligned && (idx[11:3] == GRP_BASE[11:3]);
	wire mapped      = sel_ie | sel_gs | sel_cmd | sel_up | sel_mid | sel_sel | sel_gie |
	                   sel_gsie | sel_lie | sel_link | sel_grp;

	assign pready  = 1'b1;
	assign pslverr = acc & ~mapped;

	// pin events: three stages, event set when stages two and three agree high
	wire [3:0] ev_now = ev_sync2_reg & ev_sync3_reg;
	always @(posedge ref_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			ev_sync1_reg <= 4'h0;
			ev_sync2_reg <= 4'h0;
			ev_sync3_reg <= 4'h0;
		end
		else
		begin
			ev_sync1_reg <= {utopia_out_clk_lost, utopia_in_clk_lost,
			                 tx_fifo_overflow, tx_cell_ram_full};
			ev_sync2_reg <= ev_sync1_reg;
			ev_sync3_reg <= ev_sync2_reg;
		end
	end

	// general status: set wins over a clearing write
	always @(posedge ref_clk or negedge nrst)
	begin
		if (!nrst)
			gen_status_reg <= 4'h0;
		else if (wr && sel_gs)
			gen_status_reg <= (gen_status_reg & wd[3:0]) | ev_now;
		else
			gen_status_reg <= gen_status_reg | ev_now;
	end

	// per-link and per-group sticky status
	genvar gi;
	generate
		for (gi = 0; gi < NLINK; gi = gi + 1)
		begin : g_link
			wire [12:0] ev = link_ovf_event[gi*13 +: 13];
			wire        hit = wr && sel_link && (idx[3:0] == gi);
			always @(posedge ref_clk or negedge nrst)
			begin
				if (!nrst)
					link_ovf_reg[gi] <= 13'h0000;
				else if (hit)
					link_ovf_reg[gi] <= (link_ovf_reg[gi] & wd[12:0]) | ev;
				else
					link_ovf_reg[gi] <= link_ovf_reg[gi] | ev;
			end
		end
		for (gi = 0; gi < NGRP; gi = gi + 1)
		begin : g_grp
			wire [4:0] ev = grp_ovf_event[gi*5 +: 5];
			wire       hit = wr && sel_grp && (idx[2:0] == gi);
			always @(posedge ref_clk or negedge nrst)
			begin
				if (!nrst)
					grp_ovf_reg[gi] <= 5'h00;
				else if (hit)
					grp_ovf_reg[gi] <= (grp_ovf_reg[gi] & wd[4:0]) | ev;
				else
					grp_ovf_reg[gi] <= grp_ovf_reg[gi] | ev;
			end
		end
	endgenerate

	// plain enable and holding registers
	always @(posedge ref_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			grp_fifo_ie_reg   <= 8'h00;
			grp_ovf_ie_reg    <= 8'h00;
			gen_status_ie_reg <= 4'h0;
			link_ovf_ie_reg   <= {NLINK{1'b0}};
			cnt_upper_reg     <= 8'h00;
			cnt_mid_reg       <= 16'h0000;
			cnt_select_reg    <= 9'h000;
		end
		else
		begin
			if (wr && sel_ie)
				grp_fifo_ie_reg <= wd[7:0];
			if (wr && sel_gie)
				grp_ovf_ie_reg <= wd[7:0];
			if (wr && sel_gsie)
				gen_status_ie_reg <= wd[3:0];
			// one enable per link covers all thirteen of its flags
			if (wr && sel_lie)
				link_ovf_ie_reg <= wd[NLINK-1:0];
			if (wr && sel_sel)
				cnt_select_reg <= wd[8:0];
			if (xfer_rvalid)
			begin
				cnt_upper_reg <= xfer_rdata[23:16];
				cnt_mid_reg   <= xfer_rdata[15:0];
			end
			else
			begin
				if (wr && sel_up)
					cnt_upper_reg <= wd[7:0];
				if (wr && sel_mid)
					cnt_mid_reg <= wd;
			end
		end
	end

	// transfer command, toggle and completion
	wire cmd_wr = wr && sel_cmd;
	always @(posedge ref_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			cmd_reg        <= `CCOI_RST_XFER_CMD;
			xfer_busy_reg  <= 1'b0;
			xfer_cnt_reg   <= 4'h0;
			xfer_start     <= 1'b0;
			xfer_op        <= 2'h0;
			xfer_dir       <= 1'b0;
			xfer_ie_val    <= 1'b0;
			xfer_cnt_type  <= 4'h0;
			xfer_cnt_index <= 5'h00;
			xfer_wdata     <= 24'h000000;
		end
		else
		begin
			xfer_start <= 1'b0;
			if (cmd_wr)
			begin
				cmd_reg[10:8] <= wd[10:8];
				cmd_reg[5:0]  <= {2'h0, wd[3:0]};
				cmd_reg[`CCOI_CMD_DONE] <= 1'b0;
				cmd_reg[`CCOI_CMD_TOGGLE] <= ~cmd_reg[`CCOI_CMD_TOGGLE];
				// unused operation starts nothing and sets done
				if (wd[1:0] != 2'h3)
				begin
					xfer_busy_reg  <= 1'b1;
					xfer_cnt_reg   <= `CCOI_XFER_CYCLES;
					xfer_start     <= 1'b1;
					xfer_op        <= wd[1:0];
					xfer_dir       <= wd[`CCOI_CMD_DIR];
					xfer_ie_val    <= (wd[1:0] == `CCOI_OP_IE) & wd[`CCOI_CMD_IE_VAL];
					xfer_cnt_type  <= cnt_select_reg[8:5];
					xfer_cnt_index <= cnt_select_reg[4:0];
					xfer_wdata     <= {cnt_upper_reg, cnt_mid_reg};
				end
				else
					cmd_reg[`CCOI_CMD_DONE] <= 1'b1;
			end
			else
			begin
				// writes to this block are device writes too
				if (any_write_access || wr)
					cmd_reg[`CCOI_CMD_TOGGLE] <= ~cmd_reg[`CCOI_CMD_TOGGLE];
				if (xfer_busy_reg)
				begin
					if (xfer_cnt_reg == 4'h1)
					begin
						xfer_busy_reg <= 1'b0;
						cmd_reg[`CCOI_CMD_DONE] <= 1'b1;
					end
					xfer_cnt_reg <= xfer_cnt_reg - 4'h1;
				end
			end
		end
	end

	// snapshot clock pin: three stages, edge when stages two and three agree high
	wire snap_edge = snap_sync_reg[1] & snap_sync_reg[2] & ~snap_hold_reg;
	wire [1:0] mode = cmd_reg[9:8];
	wire soft_rise = cmd_wr && wd[`CCOI_CMD_SNAP_TRIG] && !cmd_reg[`CCOI_CMD_SNAP_TRIG];
	always @(posedge ref_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			snap_sync_reg  <= 3'h0;
			snap_hold_reg  <= 1'b0;
			snap_div_reg   <= 13'h0000;
			snapshot_pulse <= 1'b0;
		end
		else
		begin
			snap_sync_reg <= {snap_sync_reg[1:0], counter_snapshot_clock};
			// hold follows the pin only once both late stages agree, so no repeat edge
			if (snap_sync_reg[1] == snap_sync_reg[2])
				snap_hold_reg <= snap_sync_reg[2];
			snapshot_pulse <= 1'b0;
			case (mode)
				`CCOI_MODE_OFF:
					snap_div_reg <= 13'h0000;
				`CCOI_MODE_EVERY:
					snapshot_pulse <= snap_edge;
				`CCOI_MODE_DIVIDED:
					if (snap_edge)
					begin
						if (snap_div_reg == `CCOI_SNAP_DIV - 1)
						begin
							snap_div_reg   <= 13'h0000;
							snapshot_pulse <= 1'b1;
						end
						else
							snap_div_reg <= snap_div_reg + 13'h0001;
					end
				`CCOI_MODE_SOFT:
					snapshot_pulse <= soft_rise && (wd[9:8] == `CCOI_MODE_SOFT);
				default:
					snapshot_pulse <= 1'b0;
			endcase
		end
	end

	// interrupt: any sticky bit with its enable
	wire [NGRP-1:0]  grp_hit;
	wire [NLINK-1:0] link_hit;
	generate
		for (gi = 0; gi < NGRP; gi = gi + 1)
		begin : g_gi
			assign grp_hit[gi] = (grp_ovf_reg[gi][4] & grp_fifo_ie_reg[gi]) |
			                     ((|grp_ovf_reg[gi][3:0]) & grp_ovf_ie_reg[gi]);
		end
		for (gi = 0; gi < NLINK; gi = gi + 1)
		begin : g_li
			assign link_hit[gi] = (|link_ovf_reg[gi]) & link_ovf_ie_reg[gi];
		end
	endgenerate
	assign irq = (|grp_hit) | (|link_hit) | (|(gen_status_reg & gen_status_ie_reg));

	// read mux; unused bits zero
	reg [15:0] rd;
	always @*
	begin
		rd = 16'h0000;
		if (sel_ie)
			rd = {8'h00, grp_fifo_ie_reg};
		else if (sel_gs)
			rd = {12'h000, gen_status_reg};
		else if (sel_cmd)
			rd = {5'h00, cmd_reg[10:0]};
		else if (sel_up)
			rd = {8'h00, cnt_upper_reg};
		else if (sel_mid)
			rd = cnt_mid_reg;
		else if (sel_sel)
			rd = {7'h00, cnt_select_reg};
		else if (sel_gie)
			rd = {8'h00, grp_ovf_ie_reg};
		else if (sel_gsie)
			rd = {12'h000, gen_status_ie_reg};
		else if (sel_lie)
			rd = link_ovf_ie_reg;
		else if (sel_link)
			rd = {3'h0, link_ovf_reg[idx[3:0]]};
		else if (sel_grp)
			rd = {11'h000, grp_ovf_reg[idx[2:0]]};
	end
	// captured in the setup cycle; a flag set during the access shows on the next read
	reg [15:0] prdata_reg;
	always @(posedge ref_clk or negedge nrst)
	begin
		if (!nrst)
			prdata_reg <= 16'h0000;
		else if (psel && !penable && !pwrite)
			prdata_reg <= rd;
	end
	assign prdata = {16'h0000, prdata_reg};
endmodule // ccoi_top

// file: ccoi_chk_sva.sv
`timescale 1ns/1ps
`include "ccoi_regs.vh"
module ccoi_chk (
	input wire        ref_clk,
	input wire        nrst,
	input wire        psel,
	input wire        penable,
	input wire        pwrite,
	input wire [15:0] paddr,
	input wire [31:0] pwdata,
	input wire [31:0] prdata,
	input wire        pslverr,
	input wire        xfer_start,
	input wire [1:0]  xfer_op,
	input wire        xfer_dir,
	input wire        xfer_ie_val,
	input wire        snapshot_pulse
);
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!nrst);
	wire acc = psel && penable;
	wire cmd_wr = acc && pwrite && paddr[15:2] == `CCOI_IDX_XFER_CMD && paddr[1:0] == 2'h0;
	wire go = cmd_wr && pwdata[1:0] != 2'h3;
	a_upper_zero: assert property (acc && !pwrite |-> prdata[31:16] == 16'h0)
		else $error("upper read bits not zero");
	a_unmapped_err: assert property (acc && paddr[15:2] == 14'h40d |-> pslverr)
		else $error("no error on unmapped index");
	a_cmd_start: assert property (go |=> xfer_start)
		else $error("command did not start");
	a_cmd_op: assert property (go |=> xfer_op == $past(pwdata[1:0]))
		else $error("operation field wrong");
	a_cmd_dir: assert property (go |=> xfer_dir == $past(pwdata[2]))
		else $error("direction wrong");
	a_cmd_ie: assert property (go |=> xfer_ie_val ==
		($past(pwdata[1:0]) == 2'h2 && $past(pwdata[3])))
		else $error("enable value wrong");
	a_op3_idle: assert property (cmd_wr && pwdata[1:0] == 2'h3 |=> !xfer_start)
		else $error("unused operation started");
	a_start_pulse: assert property ($rose(xfer_start) |=> !xfer_start)
		else $error("start longer than one cycle");
	a_snap_pulse: assert property (snapshot_pulse |=> !snapshot_pulse)
		else $error("snapshot longer than one cycle");
	c_read: cover property (go && pwdata[2]);
	c_snap: cover property (snapshot_pulse);
	c_err: cover property (acc && pslverr);
endmodule // ccoi_chk
bind ccoi_top ccoi_chk chk_i (.ref_clk(ref_clk), .nrst(nrst), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
	.prdata(prdata), .pslverr(pslverr), .xfer_start(xfer_start), .xfer_op(xfer_op),
	.xfer_dir(xfer_dir), .xfer_ie_val(xfer_ie_val), .snapshot_pulse(snapshot_pulse));

// file: ccoi_cnt_model.sv
`timescale 1ns/1ps
module ccoi_cnt_model #(
	parameter DLY = 2
) (
	input  wire        ref_clk,
	input  wire        nrst,
	input  wire        xfer_start,
	input  wire [1:0]  xfer_op,
	input  wire        xfer_dir,
	input  wire [23:0] xfer_wdata,
	output reg         xfer_rvalid,
	output reg  [23:0] xfer_rdata
);
	reg [23:0] cnt_reg;
	reg [3:0]  wait_reg;
	always @(posedge ref_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			cnt_reg <= 24'h000000;
			wait_reg <= 4'h0;
			xfer_rvalid <= 1'b0;
			xfer_rdata <= 24'h5a5a5a;
		end
		else
		begin
			xfer_rvalid <= wait_reg == 4'h1;
			// idle data keeps changing so a stale capture shows
			xfer_rdata <= (wait_reg == 4'h1) ? cnt_reg : ~xfer_rdata;
			if (wait_reg != 4'h0)
				wait_reg <= wait_reg - 4'h1;
			if (xfer_start && xfer_op == 2'h0)
				cnt_reg <= 24'h000000;
			else if (xfer_start && xfer_op == 2'h1 && !xfer_dir)
				cnt_reg <= xfer_wdata;
			else if (xfer_start && xfer_op == 2'h1)
				wait_reg <= DLY[3:0];
		end
	end
endmodule // ccoi_cnt_model

// file: tb_cell_counter_overflow_irq.sv
`timescale 1ns/1ps
`include "ccoi_regs.vh"
module tb_cell_counter_overflow_irq;
	reg          ref_clk, nrst, psel, penable, pwrite, any_write_access;
	reg          counter_snapshot_clock, utopia_out_clk_lost, utopia_in_clk_lost;
	reg          tx_fifo_overflow, tx_cell_ram_full;
	reg  [15:0]  paddr;
	reg  [31:0]  pwdata, rd_q;
	reg  [207:0] link_ovf_event;
	reg  [39:0]  grp_ovf_event;
	wire [31:0]  prdata;
	wire         pready, pslverr, snapshot_pulse, xfer_start, xfer_dir, xfer_ie_val;
	wire         xfer_rvalid, irq;
	wire [1:0]   xfer_op;
	wire [3:0]   xfer_cnt_type;
	wire [4:0]   xfer_cnt_index;
	wire [23:0]  xfer_wdata, xfer_rdata;
	reg          err_q;
	integer      n_mismatch, compares, n_snap, cyc;
	ccoi_top dut (.ref_clk, .nrst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
		.pready, .pslverr, .any_write_access, .counter_snapshot_clock,
		.utopia_out_clk_lost, .utopia_in_clk_lost, .tx_fifo_overflow, .tx_cell_ram_full,
		.link_ovf_event, .grp_ovf_event, .snapshot_pulse, .xfer_start, .xfer_op,
		.xfer_dir, .xfer_ie_val, .xfer_cnt_type, .xfer_cnt_index, .xfer_wdata,
		.xfer_rvalid, .xfer_rdata, .irq);
	ccoi_cnt_model #(.DLY(2)) far_i (.ref_clk, .nrst, .xfer_start, .xfer_op,
		.xfer_dir, .xfer_wdata, .xfer_rvalid, .xfer_rdata);
	initial
	begin
		ref_clk = 1'b0;
		forever #20 ref_clk = ~ref_clk;
	end
	always @(posedge ref_clk)
	begin
		cyc = cyc + 1;
		if (snapshot_pulse === 1'b1)
			n_snap = n_snap + 1;
		if (cyc == 80000)
		begin
			n_mismatch = n_mismatch + 1;
			results;
		end
	end
	task results;
	begin
		if (n_mismatch == 0 && compares > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	end
	endtask
	task chk(input [8*8-1:0] nm, input [31:0] e, input [31:0] g);
	begin
		compares = compares + 1;
		if (g !== e)
		begin
			n_mismatch = n_mismatch + 1;
			$display("[ERR] %0s exp %h got %h", nm, e, g);
		end
	end
	endtask
	task hold(input integer n);
		repeat (n) @(posedge ref_clk);
	endtask
	task apb(input [11:0] i, input w, input [31:0] d);
	begin
		@(posedge ref_clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= {2'h0, i, 2'h0};
		pwdata <= d;
		@(posedge ref_clk);
		penable <= 1'b1;
		@(posedge ref_clk);
		while (pready !== 1'b1)
			@(posedge ref_clk);
		rd_q = prdata;
		err_q = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	end
	endtask
	task wr(input [11:0] i, input [31:0] d);
		apb(i, 1'b1, d);
	endtask
	task rd(input [8*8-1:0] nm, input [11:0] i, input [31:0] e, input [31:0] m);
	begin
		apb(i, 1'b0, 32'h0);
		chk(nm, e & m, rd_q & m);
	end
	endtask
	task edges(input integer n);
		repeat (n)
		begin
			counter_snapshot_clock <= 1'b1;
			hold(4);
			counter_snapshot_clock <= 1'b0;
			hold(4);
		end
	endtask
	initial
	begin
		{nrst, psel, penable, pwrite, any_write_access, counter_snapshot_clock} = 6'h0;
		{utopia_out_clk_lost, utopia_in_clk_lost, tx_fifo_overflow, tx_cell_ram_full} = 4'h0;
		{paddr, pwdata, link_ovf_event, grp_ovf_event} = 0;
		{n_mismatch, compares, n_snap, cyc} = 0;
		hold(16);
		nrst <= 1'b1;
		rd("status", `CCOI_IDX_GEN_STATUS, 32'h0, 32'hffffffff);
		rd("cmd", `CCOI_IDX_XFER_CMD, 32'h0080, 32'hffdf);
		rd("grp", `CCOI_IDX_GRP_OVF_BASE + 12'h7, 32'h0, 32'hffff);
		wr(`CCOI_IDX_GRP_FIFO_IE, 32'hffffffff);
		rd("ie", `CCOI_IDX_GRP_FIFO_IE, 32'h00ff, 32'hffffffff);
		wr(`CCOI_IDX_GRP_FIFO_IE, 32'h0);
		any_write_access <= 1'b1;
		hold(1);
		any_write_access <= 1'b0;
		rd("toggle", `CCOI_IDX_XFER_CMD, 32'h0040, 32'h0040);
		wr(`CCOI_IDX_GRP_FIFO_IE, 32'h0);
		rd("toggle0", `CCOI_IDX_XFER_CMD, 32'h0, 32'h0040);
		apb(12'h40d, 1'b0, 32'h0);
		chk("slverr", 32'h1, {31'h0, err_q});
		{utopia_out_clk_lost, utopia_in_clk_lost, tx_fifo_overflow, tx_cell_ram_full} <= 4'hf;
		hold(4);
		{utopia_out_clk_lost, utopia_in_clk_lost, tx_fifo_overflow, tx_cell_ram_full} <= 4'h0;
		hold(4);
		wr(`CCOI_IDX_GEN_STATUS, 32'hffff);
		rd("status", `CCOI_IDX_GEN_STATUS, 32'h000f, 32'hffff);
		wr(`CCOI_IDX_GEN_STATUS, 32'h0);
		rd("status", `CCOI_IDX_GEN_STATUS, 32'h0, 32'hffff);
		link_ovf_event <= {13'h1555, 182'h0, 13'h0aaa};
		hold(1);
		link_ovf_event <= 208'h0;
		rd("link15", `CCOI_IDX_LINK_OVF_BASE + 12'hf, 32'h1555, 32'hffff);
		rd("link0", `CCOI_IDX_LINK_OVF_BASE, 32'h0aaa, 32'hffff);
		wr(`CCOI_IDX_LINK_OVF_IE, 32'h8000);
		hold(1);
		chk("irq", 32'h1, {31'h0, irq});
		wr(`CCOI_IDX_LINK_OVF_BASE + 12'hf, 32'h0);
		hold(1);
		chk("irq", 32'h0, {31'h0, irq});
		grp_ovf_event <= {5'h1f, 35'h0};
		hold(1);
		grp_ovf_event <= 40'h0;
		rd("grp7", `CCOI_IDX_GRP_OVF_BASE + 12'h7, 32'h1f, 32'hffff);
		wr(`CCOI_IDX_GRP_FIFO_IE, 32'h0080);
		hold(1);
		chk("irq", 32'h1, {31'h0, irq});
		wr(`CCOI_IDX_GRP_FIFO_IE, 32'h0040);
		hold(1);
		chk("irq", 32'h0, {31'h0, irq});
		wr(`CCOI_IDX_GRP_OVF_IE, 32'h0080);
		wr(`CCOI_IDX_GRP_OVF_BASE + 12'h7, 32'h0);
		hold(1);
		chk("irq", 32'h0, {31'h0, irq});
		wr(`CCOI_IDX_CNT_SELECT, 32'h00e5);
		wr(`CCOI_IDX_CNT_UPPER, 32'h12);
		wr(`CCOI_IDX_CNT_MID, 32'h3456);
		wr(`CCOI_IDX_XFER_CMD, 32'h0009);
		rd("pending", `CCOI_IDX_XFER_CMD, 32'h0, 32'h0080);
		chk("sel", 32'h00e5, {23'h0, xfer_cnt_type, xfer_cnt_index});
		chk("wdata", 32'h123456, {8'h0, xfer_wdata});
		chk("op", 32'h1, {28'h0, xfer_ie_val, xfer_dir, xfer_op});
		hold(4);
		rd("done", `CCOI_IDX_XFER_CMD, 32'h0089, 32'h038f);
		wr(`CCOI_IDX_CNT_UPPER, 32'h0);
		wr(`CCOI_IDX_CNT_MID, 32'h0);
		wr(`CCOI_IDX_XFER_CMD, 32'h0005);
		hold(6);
		rd("upper", `CCOI_IDX_CNT_UPPER, 32'h12, 32'hffffffff);
		rd("mid", `CCOI_IDX_CNT_MID, 32'h3456, 32'hffffffff);
		wr(`CCOI_IDX_XFER_CMD, 32'h0004);
		hold(6);
		wr(`CCOI_IDX_XFER_CMD, 32'h0005);
		hold(6);
		rd("cleared", `CCOI_IDX_CNT_MID, 32'h0, 32'hffff);
		wr(`CCOI_IDX_XFER_CMD, 32'h000a);
		hold(5);
		chk("op_ie", 32'h000a, {28'h0, xfer_ie_val, xfer_dir, xfer_op});
		wr(`CCOI_IDX_XFER_CMD, 32'h0303);
		wr(`CCOI_IDX_XFER_CMD, 32'h0703);
		hold(8);
		chk("soft", 32'h1, n_snap);
		rd("op3", `CCOI_IDX_XFER_CMD, 32'h0080, 32'h0080);
		wr(`CCOI_IDX_XFER_CMD, 32'h0303);
		hold(8);
		chk("soft0", 32'h1, n_snap);
		wr(`CCOI_IDX_XFER_CMD, 32'h0103);
		edges(3);
		chk("every", 32'h4, n_snap);
		wr(`CCOI_IDX_XFER_CMD, 32'h0003);
		edges(2);
		chk("none", 32'h4, n_snap);
		wr(`CCOI_IDX_XFER_CMD, 32'h0203);
		edges(8000);
		hold(8);
		chk("divided", 32'h5, n_snap);
		results;
	end
endmodule // tb_cell_counter_overflow_irq
